//--- cwdlo_pkg.sv
// constants and types shared by the cw doppler lo phase programmer
package cwdlo_pkg;
  // channel and serial word geometry
  localparam int NUM_CH = 8, WORD_W = 5, PHASE_W = 4, CHAIN_W = 40;
  // field positions inside one channel word: soft-off at bit 0, phase above it
  localparam int SOFT_OFF_POS = 0, PH_LSB = 1;
  // lanes of the pin synchroniser
  localparam int SYNC_W = 12;
  localparam int LN_SCLK = 0, LN_DIN = 1, LN_LOAD = 2, LN_MIX = 3, LN_CH0 = 4;
  // synchroniser reset image: load line idles high, all else low
  localparam logic [11:0] SYNC_RESET = 12'h004;
  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00, REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HELD_LO = 8'h08, REG_HELD_HI = 8'h0C;
  localparam logic [7:0] REG_CHAIN_LO = 8'h10, REG_CHAIN_HI = 8'h14;
  // control register fields
  localparam int CTRL_MSL_POS = 0, CTRL_MSH_POS = 1, CTRL_PWRDN_POS = 2;
  // status register fields
  localparam int STAT_EN_LSB = 0, STAT_MODE_LSB = 8, STAT_LOAD_POS = 10;
  localparam int STAT_PWRDN_POS = 11;
  // values after reset
  localparam logic MSEL_RESET = 1'b0, PWRDN_RESET = 1'b0;
  localparam logic [39:0] CHAIN_RESET = 40'h0000000000;
  localparam logic [3:0] CNT_RESET = 4'h0;
  // mode select encodings
  typedef enum logic [1:0] {
    MODE_DIV16 = 2'b00,
    MODE_DIV8 = 2'b01,
    MODE_DIV4 = 2'b10,
    MODE_QUAD = 2'b11
  } cwdlo_mode_t;
  // counter moduli masks and their top-bit weights per mode
  localparam logic [3:0] MASK_16 = 4'hF, MASK_8 = 4'h7, MASK_4 = 4'h3;
  localparam logic [3:0] TOP_16 = 4'h8, TOP_8 = 4'h4, TOP_4 = 4'h2;
endpackage

//--- cwdlo_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module cwdlo_pin_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [cwdlo_pkg::SYNC_W-1:0] pin,
  output logic [cwdlo_pkg::SYNC_W-1:0] level,
  output logic [cwdlo_pkg::SYNC_W-1:0] rise,
  output logic [cwdlo_pkg::SYNC_W-1:0] fall
);
  import cwdlo_pkg::*;

  // s1 feeds only s2; the filter looks at s2 and s3
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] lvl;
  } cwdlo_sync_t;

  cwdlo_sync_t st;
  cwdlo_sync_t next_st;

  // shift the chain; accept a new level only once s2 and s3 agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));
  end

  // state register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st <= {4{SYNC_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // pulses lead the level change by one cycle and last one cycle
  assign level = st.lvl;
  assign rise = st.s2 & st.s3 & ~st.lvl;
  assign fall = ~st.s2 & ~st.s3 & st.lvl;
endmodule

//--- cwdlo_phase_gen.sv
// one channel: loadable phase counter dividing its clock into i and q
`timescale 1ns/100ps
module cwdlo_phase_gen (
  input wire logic mclk,
  input wire logic resetn,
  input wire cwdlo_pkg::cwdlo_mode_t mode,
  input wire logic tick,
  input wire logic load,
  input wire logic [cwdlo_pkg::PHASE_W-1:0] code,
  input wire logic chan_on,
  output logic lo_i,
  output logic lo_q
);
  import cwdlo_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] cnt; // phase counter
    logic i; // in-phase lo
    logic q; // quadrature lo
  } cwdlo_gen_t;

  cwdlo_gen_t st;
  cwdlo_gen_t next_st;
  logic [PHASE_W-1:0] mask; // modulus minus one
  logic [PHASE_W-1:0] top; // weight of the output bit

  // modulus per mode
  always_comb begin
    case (mode)
      // sixteen phases from all four bits
      MODE_DIV16: begin
        mask = MASK_16;
        top = TOP_16;
      end
      MODE_DIV8: begin
        mask = MASK_8;
        top = TOP_8;
      end
      // four phases, two top bits dropped
      default: begin
        mask = MASK_4;
        top = TOP_4;
      end
    endcase
  end

  // count, load, and derive i/q; q leads i by a quarter of the modulus
  always_comb begin
    next_st = st;
    if (load) begin
      // quad mode ignores the code; every channel starts at zero
      next_st.cnt = (mode == MODE_QUAD) ? CNT_RESET : (code & mask);
    end else if (tick) begin
      next_st.cnt = (st.cnt + 4'h1) & mask;
    end
    // code steps the phase evenly; off forces low
    next_st.i = chan_on & (|(next_st.cnt & top));
    next_st.q = chan_on & (|(((next_st.cnt + (top >> 1)) & mask) & top));
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lo_i = st.i;
  assign lo_q = st.q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_load_phase_code: assert property (
    load && mode != MODE_QUAD |=> st.cnt == ($past(code) & $past(mask))
  ) else $error("phase counter did not take the masked code");
  a_quad_start_zero: assert property (
    load && mode == MODE_QUAD |=> st.cnt == 4'h0 && !lo_i
  ) else $error("quad mode load did not clear the counter");
  a_off_outputs_low: assert property (
    !chan_on |=> !lo_i && !lo_q
  ) else $error("lo driven while channel is off");
  a_count_in_range: assert property (
    load ##1 !load [*2] |-> (st.cnt & ~mask) == 4'h0
  ) else $error("counter exceeded modulus of mode");
endmodule

//--- cwdlo_lo_programmer.sv
// eight-channel lo phase programmer with serial chain and wishbone control
//
// How it works
// - two select bits pick one of four modes
// - mode one divides mixer clock by sixteen
// - each of eight channels has own phase
// - five-bit chain segment per channel
// - four phase bits, then one enable bit
// - mode two divides mixer clock by eight
// - mode two ignores top phase bit
// - mode three divides channel clock by four
// - mode three ignores two top bits
// - mode four makes quadrature from channel clock
// - one shared chain programs modes one-three
// - modes 1-2 shared clock, 3-4 per-channel
// - chip power-down overrides channel soft enable
// - soft-off kills only that channel's lo
// - soft-off one is off; code sets phase
// - chain end drives serial output pin
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module cwdlo_lo_programmer (
  input wire logic mclk,
  input wire logic resetn,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial programming pins
  input wire logic serial_clk,
  input wire logic serial_din,
  input wire logic load_n,
  output logic serial_dout,
  // lo clock pins
  input wire logic mixer_clk,
  input wire logic [cwdlo_pkg::NUM_CH-1:0] per_channel_quad_clock,
  // per-channel lo outputs and power
  output logic [cwdlo_pkg::NUM_CH-1:0] lo_i,
  output logic [cwdlo_pkg::NUM_CH-1:0] lo_q,
  output logic [cwdlo_pkg::NUM_CH-1:0] mixer_enable
);
  import cwdlo_pkg::*;

  // all state of the block
  typedef struct packed {
    logic mode_select_high; // upper mode bit
    logic mode_select_low; // lower mode bit
    logic chip_power_down; // overrides every channel
    logic [CHAIN_W-1:0] chain; // live shift chain
    logic [CHAIN_W-1:0] held; // words taken at load
    logic load_pulse; // delayed load toward the counters
    logic ack; // wishbone answer
    logic [31:0] rdata; // read data with the answer
    logic [NUM_CH-1:0] mixer_enable; // mixer and lo buffer power
    logic serial_dout; // chain end toward the next device
  } cwdlo_state_t;

  cwdlo_state_t st;
  cwdlo_state_t next_st;

  // synchronised pins
  logic [SYNC_W-1:0] pin_bus; // raw pins gathered into lanes
  logic [SYNC_W-1:0] pin_lvl; // filtered levels
  logic [SYNC_W-1:0] pin_rise; // one-cycle rising pulses

  // derived controls
  cwdlo_mode_t mode; // decoded mode
  logic shift_en; // one chain step this cycle
  logic load_done; // load line returned high
  logic din_lvl; // serial data level
  logic [NUM_CH-1:0] ch_rise; // per-channel clock edges
  logic [NUM_CH-1:0] tick; // counter step per channel
  logic [NUM_CH-1:0] channel_soft_off; // soft-off bit per channel
  logic [PHASE_W-1:0] phase_code [NUM_CH]; // phase bits per channel
  logic wb_req; // new wishbone request

  // every pin crosses in here; the mixer clock is only a slow
  // edge marker at this clock rate, so real lo rates need a faster core
  assign pin_bus = {per_channel_quad_clock, mixer_clk, load_n, serial_din, serial_clk};

  cwdlo_pin_sync u_sync (
    .mclk (mclk),
    .resetn (resetn),
    .pin (pin_bus),
    .level (pin_lvl),
    .rise (pin_rise),
    .fall ()
  );

  assign mode = cwdlo_mode_t'({st.mode_select_high, st.mode_select_low});

  assign shift_en = pin_rise[LN_SCLK] & pin_lvl[LN_LOAD];
  // the load line must go low first, so its return high is the event
  assign load_done = pin_rise[LN_LOAD];
  assign din_lvl = pin_lvl[LN_DIN];
  assign ch_rise = pin_rise[LN_CH0 +: NUM_CH];

  always_comb begin
    if (mode == MODE_DIV4 || mode == MODE_QUAD) begin
      tick = ch_rise;
    end else begin
      tick = {NUM_CH{pin_rise[LN_MIX]}};
    end
  end

  // one counter per channel, fed from its own word
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      // phase bits above the soft-off bit
      assign channel_soft_off[c] = st.held[c*WORD_W + SOFT_OFF_POS];
      assign phase_code[c] = st.held[c*WORD_W + PH_LSB +: PHASE_W];

      cwdlo_phase_gen u_gen (
        .mclk (mclk),
        .resetn (resetn),
        .mode (mode),
        .tick (tick[c]),
        .load (st.load_pulse),
        .code (phase_code[c]),
        .chan_on (st.mixer_enable[c]),
        .lo_i (lo_i[c]),
        .lo_q (lo_q[c])
      );
    end
  endgenerate

  // a request is new until we have answered it
  assign wb_req = wb_cyc_i & wb_stb_i & ~st.ack;

  // next-state logic
  always_comb begin
    next_st = st;

    // one bit per serial clock rise while load is high, shifted toward the top
    if (shift_en) begin
      next_st.chain = {st.chain[CHAIN_W-2:0], din_lvl};
    end
    // chain top is the daisy-chain output
    next_st.serial_dout = next_st.chain[CHAIN_W-1];

    // the one chain is copied as a whole on load
    if (load_done) begin
      next_st.held = st.chain;
    end
    // counters load one cycle later so they see the new words
    next_st.load_pulse = load_done;

    // power-down wins over the soft enable
    // soft-off removes only that channel's mixer and buffer
    // a set soft-off bit means off
    next_st.mixer_enable = ~channel_soft_off & {NUM_CH{~st.chip_power_down}};

    // wishbone: answer every request one cycle later, drop next cycle
    next_st.ack = wb_req;
    next_st.rdata = 32'h00000000;
    if (wb_req && wb_we_i) begin
      // only the control register takes writes; others ignore them
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        next_st.mode_select_low = wb_dat_i[CTRL_MSL_POS];
        next_st.mode_select_high = wb_dat_i[CTRL_MSH_POS];
        next_st.chip_power_down = wb_dat_i[CTRL_PWRDN_POS];
      end
    end else if (wb_req) begin
      // reads: unmapped offsets answer with zero
      if (wb_adr_i == REG_CTRL) begin
        // control bits read back as written
        next_st.rdata[CTRL_MSL_POS] = st.mode_select_low;
        next_st.rdata[CTRL_MSH_POS] = st.mode_select_high;
        next_st.rdata[CTRL_PWRDN_POS] = st.chip_power_down;
      end else if (wb_adr_i == REG_STATUS) begin
        // enables, decoded mode, filtered load level, power-down
        next_st.rdata[STAT_EN_LSB +: NUM_CH] = st.mixer_enable;
        next_st.rdata[STAT_MODE_LSB +: 2] = mode;
        next_st.rdata[STAT_LOAD_POS] = pin_lvl[LN_LOAD];
        next_st.rdata[STAT_PWRDN_POS] = st.chip_power_down;
      end else if (wb_adr_i == REG_HELD_LO) begin
        // loaded words, channels zero to five and two bits of six
        next_st.rdata = st.held[31:0];
      end else if (wb_adr_i == REG_HELD_HI) begin
        // loaded words, top byte only
        next_st.rdata = {24'h000000, st.held[CHAIN_W-1:32]};
      end else if (wb_adr_i == REG_CHAIN_LO) begin
        // live chain, so software can verify a shift before loading
        next_st.rdata = st.chain[31:0];
      end else if (wb_adr_i == REG_CHAIN_HI) begin
        // live chain, top byte only
        next_st.rdata = {24'h000000, st.chain[CHAIN_W-1:32]};
      end
    end
  end

  // state register, synchronous active-low reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st.mode_select_high <= MSEL_RESET;
      st.mode_select_low <= MSEL_RESET;
      st.chip_power_down <= PWRDN_RESET;
      st.chain <= CHAIN_RESET;
      st.held <= CHAIN_RESET;
      st.load_pulse <= 1'b0;
      st.ack <= 1'b0;
      st.rdata <= 32'h00000000;
      // enables come up on the first cycle after release
      st.mixer_enable <= 8'h00;
      st.serial_dout <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs from flip-flops; ack is the answer strobe
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign serial_dout = st.serial_dout;
  assign mixer_enable = st.mixer_enable;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // one shift step; the load returning high, then the counter load strobe
  sequence s_shift_step;
    shift_en;
  endsequence

  sequence s_load_then_count;
    load_done ##1 st.load_pulse;
  endsequence

  a_chain_shift_in: assert property (
    s_shift_step |=> st.chain[0] == $past(din_lvl)
      && st.chain[CHAIN_W-1:1] == $past(st.chain[CHAIN_W-2:0])
  ) else $error("chain did not shift in the data bit");
  a_chain_hold_idle: assert property (
    !shift_en |=> $stable(st.chain)
  ) else $error("chain moved without a shift clock");
  a_dout_follows_top: assert property (
    s_shift_step |=> serial_dout == $past(st.chain[CHAIN_W-2])
  ) else $error("serial output is not the chain end");
  a_held_on_load: assert property (
    s_load_then_count |-> st.held == $past(st.chain, 2)
  ) else $error("held words differ from the shifted chain");
  a_pwrdn_overrides: assert property (
    st.chip_power_down |=> mixer_enable == 8'h00
  ) else $error("channel powered while chip is powered down");
  a_soft_off_chan: assert property (
    !st.chip_power_down && $stable(st.held) ##1 $stable(st.held)
      |-> mixer_enable == ~channel_soft_off
  ) else $error("mixer enable disagrees with soft-off bits");
  a_tick_source: assert property (
    mode == MODE_DIV16 || mode == MODE_DIV8 |-> tick == {NUM_CH{pin_rise[LN_MIX]}}
  ) else $error("shared modes not clocked from the mixer clock");
  a_wb_ack_once: assert property (
    wb_req |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("wishbone answer not a single cycle");

  // two cycles with the chip powered down
  sequence s_powered_down;
    st.chip_power_down ##1 st.chip_power_down;
  endsequence

  // the read answer is zero outside the answer cycle
  a_rdata_idle_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h00000000
  ) else $error("read data not zero outside the answer");

  // control write lands one cycle after it is taken
  a_ctrl_write_lands: assert property (
    wb_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]
      |=> st.mode_select_low == $past(wb_dat_i[CTRL_MSL_POS])
      && st.mode_select_high == $past(wb_dat_i[CTRL_MSH_POS])
      && st.chip_power_down == $past(wb_dat_i[CTRL_PWRDN_POS])
  ) else $error("control write did not land");

  // writes elsewhere leave the control bits alone
  a_ctrl_write_refused: assert property (
    wb_req && wb_we_i && wb_adr_i != REG_CTRL
      |=> $stable({st.mode_select_high, st.mode_select_low, st.chip_power_down})
  ) else $error("control bits changed by a refused write");

  // status read returns the mode and the enables
  a_status_read: assert property (
    wb_req && !wb_we_i && wb_adr_i == REG_STATUS
      |=> wb_dat_o[STAT_MODE_LSB +: 2] == $past(mode)
      && wb_dat_o[STAT_EN_LSB +: NUM_CH] == $past(st.mixer_enable)
  ) else $error("status read disagrees with mode or enables");

  // live chain low word reads back unchanged
  a_chain_lo_read: assert property (
    wb_req && !wb_we_i && wb_adr_i == REG_CHAIN_LO
      |=> wb_dat_o == $past(st.chain[31:0])
  ) else $error("chain low word read back wrong");

  // held top byte reads back zero-extended
  a_held_hi_read: assert property (
    wb_req && !wb_we_i && wb_adr_i == REG_HELD_HI
      |=> wb_dat_o == {24'h000000, $past(st.held[CHAIN_W-1:32])}
  ) else $error("held top byte read back wrong");

  // no shift while the load line is low
  a_load_low_holds: assert property (
    !pin_lvl[LN_LOAD] |=> $stable(st.chain)
  ) else $error("chain moved while the load line was low");

  // held words change only at a load
  a_held_only_load: assert property (
    !load_done |=> $stable(st.held)
  ) else $error("held words changed without a load");

  // counters see a single load strobe per load
  a_load_pulse_once: assert property (
    st.load_pulse |=> !st.load_pulse
  ) else $error("counter load strobe longer than one cycle");

  // per-channel modes step from their own clocks
  a_tick_own_clock: assert property (
    mode == MODE_DIV4 || mode == MODE_QUAD |-> tick == ch_rise
  ) else $error("per-channel modes not clocked from their own pins");

  // a powered-down chip drives no lo at all
  a_pwrdn_lo_low: assert property (
    s_powered_down |=> lo_i == 8'h00 && lo_q == 8'h00
  ) else $error("lo driven while the chip is powered down");
endmodule

//--- cwdlo_ctrl_model.sv
// beamformer controller model: serial programming pins and lo clocks
`timescale 1ns/100ps
module cwdlo_ctrl_model (
  input wire logic mclk,
  output logic serial_clk,
  output logic serial_din,
  output logic load_n,
  output logic mixer_clk,
  output logic [7:0] per_channel_quad_clock
);
  // idle pins: load high, every clock stopped low between frames
  initial begin
    serial_clk = 1'b0;
    serial_din = 1'b0;
    load_n = 1'b1;
    mixer_clk = 1'b0;
    per_channel_quad_clock = 8'h00;
  end
  // five mclk per level, so the agreement filter never drops a level
  task automatic hold();
    repeat (5) @(posedge mclk);
  endtask
  task automatic shift(input logic [39:0] v);
    for (int i = 39; i >= 0; i--) begin
      serial_din <= v[i];
      hold();
      serial_clk <= 1'b1;
      hold();
      serial_clk <= 1'b0;
    end
    hold();
  endtask
  // load low then high, clocks stopped; poke tries a refused shift
  task automatic load(input bit poke);
    load_n <= 1'b0;
    hold();
    if (poke) begin
      serial_clk <= 1'b1;
      hold();
      serial_clk <= 1'b0;
      hold();
    end
    load_n <= 1'b1;
    hold();
    hold();
  endtask
  // shared clock or all lanes; rate scaled to the sampler
  task automatic pulse(input bit shared);
    if (shared) mixer_clk <= 1'b1;
    else per_channel_quad_clock <= 8'hFF;
    hold();
    mixer_clk <= 1'b0;
    per_channel_quad_clock <= 8'h00;
    hold();
  endtask
endmodule

//--- cwdlo_lo_programmer_test.sv
// self-checking bench for the lo phase programmer
`timescale 1ns/100ps
module cwdlo_lo_programmer_test;
  import cwdlo_pkg::*;
  logic mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serial_dout;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, q2;
  logic serial_clk, serial_din, load_n, mixer_clk;
  logic [7:0] per_channel_quad_clock, lo_i, lo_q, mixer_enable;
  logic [39:0] ch;
  logic [63:0] r64;
  logic [1:0] mb;
  int failures, n_compared, seed;
  cwdlo_lo_programmer cwdlo_lo_programmer_i (.mclk(mclk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_clk(serial_clk), .serial_din(serial_din), .load_n(load_n),
    .serial_dout(serial_dout), .mixer_clk(mixer_clk),
    .per_channel_quad_clock(per_channel_quad_clock), .lo_i(lo_i), .lo_q(lo_q),
    .mixer_enable(mixer_enable));
  cwdlo_ctrl_model cwdlo_ctrl_model_i (.mclk(mclk), .serial_clk(serial_clk),
    .serial_din(serial_din), .load_n(load_n), .mixer_clk(mixer_clk),
    .per_channel_quad_clock(per_channel_quad_clock));
  // free-running 10 mhz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // verdict and end of run
  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one comparison, counted
  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // classic single wishbone cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      test_done();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
  endtask
  // expected lo per channel after n clock rises (mixer or per-channel, by mode); q adds a quarter period
  function automatic logic [7:0] exp_lo(int m, logic [39:0] c, int n, bit qd);
    int md, cnt;
    md = (m == 0) ? 16 : (m == 1) ? 8 : 4;
    for (int i = 0; i < 8; i++) begin
      cnt = (m == 3) ? 0 : int'(c[i*5+1 +: 4]);
      cnt = (cnt + n + (qd ? md / 4 : 0)) % md;
      exp_lo[i] = !c[i*5] && cnt >= md / 2;
    end
  endfunction
  // channel powered while its soft-off bit is clear
  function automatic logic [7:0] exp_en(logic [39:0] c);
    for (int i = 0; i < 8; i++) exp_en[i] = !c[i*5];
  endfunction
  // main sequence
  initial begin
    seed = 32'h9d1b245a;
    failures = 0;
    n_compared = 0;
    resetn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (5) @(posedge mclk);
    // reset image, read-only write ignored, unmapped read zero
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(40'(q), 40'h4FF, "status after reset");
    wb(1'b1, REG_STATUS, 32'hFFFFFFFF, q);
    wb(1'b0, REG_CTRL, 32'h0, q);
    check(40'(q), 40'h0, "ctrl");
    wb(1'b0, 8'h18, 32'h0, q);
    check(40'(q), 40'h0, "unmapped read");
    for (int m = 0; m < 4; m++) begin
      mb = 2'(m);
      r64 = {$random(seed), $random(seed)};
      ch = r64[39:0];
      // corner: top channel off at code 0, channel 0 on at full code
      if (m == 0) ch = {5'h01, ch[34:5], 5'h1E};
      wb(1'b1, REG_CTRL, {30'h0, mb}, q);
      wb(1'b0, REG_STATUS, 32'h0, q);
      check(40'(q[9:8]), 40'(mb), "mode field");
      cwdlo_ctrl_model_i.shift(ch);
      check(40'(serial_dout), 40'(ch[39]), "chain out");
      wb(1'b0, REG_CHAIN_LO, 32'h0, q);
      wb(1'b0, REG_CHAIN_HI, 32'h0, q2);
      check({q2[7:0], q}, ch, "chain");
      cwdlo_ctrl_model_i.load(1'b1);
      wb(1'b0, REG_CHAIN_LO, 32'h0, q);
      wb(1'b0, REG_CHAIN_HI, 32'h0, q2);
      check({q2[7:0], q}, ch, "chain during load");
      wb(1'b0, REG_HELD_LO, 32'h0, q);
      wb(1'b0, REG_HELD_HI, 32'h0, q2);
      check({q2[7:0], q}, ch, "held words");
      check(40'(mixer_enable), 40'(exp_en(ch)), "enables");
      for (int n = 0; n < 18; n++) begin
        check(40'(lo_i), 40'(exp_lo(m, ch, n, 1'b0)), "lo i");
        check(40'(lo_q), 40'(exp_lo(m, ch, n, 1'b1)), "lo q");
        cwdlo_ctrl_model_i.pulse(m < 2);
      end
    end
    // chip power-down overrides soft enables, then releases them
    wb(1'b1, REG_CTRL, 32'h7, q);
    check(40'(mixer_enable), 40'h0, "power down");
    check(40'({lo_i, lo_q}), 40'h0, "lo off");
    wb(1'b1, REG_CTRL, 32'h3, q);
    check(40'(mixer_enable), 40'(exp_en(ch)), "power up");
    test_done();
  end
endmodule
